// ==== crtrt_top.sv ====
// CRT row refresh timing: command decode, row buffers, retrace timing and video controls.
// Assumes asynchronous host pins (strobes and data) and a one-clock system; srst_i synchronous.
`timescale 1ns/1ps
`default_nettype none
module crtrt_top #(
  parameter int CHAR_DIV = crtrt_pkg::CHAR_DIV_DEF,
  parameter int ROW_CHARS = crtrt_pkg::ROW_CHARS_DEF
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire crtrt_pkg::crtrt_ctl_t ctl_i,
  input wire logic [7:0] data_i,
  output logic [7:0] rd_data_o,
  output logic wr_ready_o,
  output logic buf_req_o,
  output logic irq_o,
  output logic underrun_o,
  output logic [6:0] char_code_o,
  output logic [3:0] line_count_o,
  output crtrt_pkg::crtrt_video_t video_o
);
  import crtrt_pkg::*;

  if (CHAR_DIV < 2 || ROW_CHARS < 1 || ROW_CHARS > 128) begin : g_bad_param
    $error("crtrt_top: CHAR_DIV or ROW_CHARS out of range");
  end

  localparam logic [7:0] DIV_LAST = 8'(CHAR_DIV - 1);
  localparam logic [6:0] ROW_LAST = 7'(ROW_CHARS - 1);

  typedef struct packed {
    logic [2:0][SYNC_W+7:0] sync;
    logic [SYNC_W+7:0] filt;
    crtrt_fmt_t fmt;
    logic [2:0] cmd;
    logic [2:0] par_left;
    logic display_en;
    logic int_en;
    logic irq;
    logic [2:0] burst_code;
    logic [2:0] space_code;
    logic [3:0] burst_left;
    logic [5:0] space_cnt;
    logic [6:0] cur_col;
    logic [5:0] cur_row;
    logic [7:0] pen_col;
    logic [6:0] pen_row;
    logic pen_byte;
    logic [1:0][7:0] fifo;
    logic fifo_wp;
    logic fifo_rp;
    logic [1:0] fifo_cnt;
    logic [1:0][ROW_CHARS-1:0][7:0] rowbuf;
    logic disp;
    logic [6:0] fill_cnt;
    logic fill_done;
    logic stop_frame;
    logic [7:0] div_cnt;
    logic [7:0] char_cnt;
    logic [3:0] line_cnt;
    logic [6:0] row_cnt;
    logic blank_row;
    logic blank_frame;
    logic underrun;
    logic attr_rev;
    logic attr_hi;
    logic [6:0] char_code;
    logic [3:0] line_out;
    crtrt_video_t video;
  } crtrt_state_t;

  crtrt_state_t q, d;
  crtrt_ctl_t ctl_f, ctl_p;
  logic [7:0] bus_f;
  logic wr_fall, rd_fall, pen_rise, reg_wr, buf_wr, push, pop, ce;
  logic line_end, row_end, frame_end, in_hdisp, in_vdisp, load_win, at_cursor;
  logic [7:0] htotal_m1, ch, pop_byte;
  logic [6:0] vtotal_m1, chars_par;
  logic [3:0] burst_len;
  logic [5:0] space_len;

  always_comb begin
    d = q;
    // Only the agreeing second and third stages may move the filtered value
    d.sync[0] = {ctl_i[12:0], data_i};
    d.sync[1] = q.sync[0];
    d.sync[2] = q.sync[1];
    for (int b = 0; b < SYNC_W + 8; b++) begin
      if (q.sync[1][b] == q.sync[2][b]) begin
        d.filt[b] = q.sync[2][b];
      end
    end
    ctl_f = crtrt_ctl_t'(d.filt[SYNC_W+7:8]);
    ctl_p = crtrt_ctl_t'(q.filt[SYNC_W+7:8]);
    bus_f = d.filt[7:0];
    wr_fall = ctl_p.wr_n & ~ctl_f.wr_n;
    rd_fall = ctl_p.rd_n & ~ctl_f.rd_n;
    pen_rise = ~ctl_p.pen & ctl_f.pen;
    reg_wr = wr_fall & ~ctl_f.cs_n; // R17
    buf_wr = wr_fall & ctl_f.cs_n & ctl_f.row_buffer_select; // R18

    htotal_m1 = {1'b0, q.fmt.chars_m1} + {3'h0, q.fmt.hrt_m1} + 8'h01;
    vtotal_m1 = {1'b0, q.fmt.rows_m1} + {5'h00, q.fmt.vrt_m1} + 7'h01;
    in_hdisp = q.char_cnt <= {1'b0, q.fmt.chars_m1};
    in_vdisp = q.row_cnt <= {1'b0, q.fmt.rows_m1};
    load_win = q.display_en & ((q.row_cnt < {1'b0, q.fmt.rows_m1}) | (q.row_cnt == vtotal_m1));
    burst_len = 4'h1 << q.burst_code[1:0]; // R14
    space_len = 6'(q.space_code * BURST_SPACE_UNIT); // R14
    chars_par = (bus_f[6:0] > ROW_LAST) ? ROW_LAST : bus_f[6:0];

    // Command and parameter writes
    if (reg_wr && !ctl_f.cmd_sel && q.par_left != 3'h0) begin
      d.par_left = q.par_left - 3'h1;
      case (q.cmd)
        CMD_RESET: begin
          case (q.par_left) // R5
            3'h4: d.fmt.chars_m1 = chars_par;
            3'h3: d.fmt.rows_m1 = bus_f[5:0];
            3'h2: begin
              d.fmt.lines_m1 = bus_f[3:0];
              d.fmt.cursor_rev = bus_f[7];
            end
            default: begin
              d.fmt.hrt_m1 = bus_f[4:0];
              d.fmt.vrt_m1 = bus_f[6:5];
              d.fmt.rev_en = bus_f[7];
            end
          endcase
        end
        CMD_CURSOR: begin
          if (q.par_left == NPAR_TWO) begin
            d.cur_col = bus_f[6:0]; // R7
          end else begin
            d.cur_row = bus_f[5:0]; // R7
          end
        end
        default: d.par_left = 3'h0;
      endcase
    end else if (reg_wr && ctl_f.cmd_sel) begin
      d.cmd = bus_f[7:5];
      d.par_left = 3'h0;
      case (bus_f[7:5])
        CMD_RESET: begin
          d.par_left = NPAR_RESET; // R5
          d.display_en = 1'b0;
        end
        CMD_START: begin
          d.display_en = 1'b1; // R6
          d.burst_code = {1'b0, bus_f[1:0]};
          d.space_code = bus_f[4:2];
          d.burst_left = 4'h1 << bus_f[1:0];
          d.space_cnt = 6'h00;
        end
        CMD_STOP: d.display_en = 1'b0; // R6
        CMD_PEN: begin
          d.par_left = NPAR_TWO; // R7
          d.pen_byte = 1'b0;
        end
        CMD_CURSOR: d.par_left = NPAR_TWO; // R7
        CMD_INT_EN: d.int_en = 1'b1; // R6
        CMD_INT_DIS: begin
          d.int_en = 1'b0; // R6
          d.irq = 1'b0;
        end
        default: ; // Preset handled below with the counters
      endcase
    end
    if (rd_fall && !ctl_f.cs_n && !ctl_f.cmd_sel && q.cmd == CMD_PEN && q.par_left != 3'h0) begin
      d.par_left = q.par_left - 3'h1; // R7
      d.pen_byte = 1'b1;
    end
    if (pen_rise) begin
      d.pen_col = q.char_cnt;
      d.pen_row = q.row_cnt;
    end

    // Two-entry buffer between the host strobes and the row buffer
    push = buf_wr & (q.fifo_cnt != 2'h2);
    pop = (q.fifo_cnt != 2'h0) & ~q.fill_done & load_win;
    pop_byte = q.fifo[q.fifo_rp];
    if (push) begin
      d.fifo[q.fifo_wp] = bus_f;
      d.fifo_wp = ~q.fifo_wp;
      if (q.burst_left != 4'h0) begin
        d.burst_left = q.burst_left - 4'h1; // R14
        if (q.burst_left == 4'h1) begin
          d.space_cnt = space_len;
        end
      end
    end
    if (pop) begin
      d.fifo_rp = ~q.fifo_rp;
      d.rowbuf[~q.disp][q.fill_cnt] = pop_byte;
      d.fill_cnt = q.fill_cnt + 7'h01;
      if (q.fill_cnt == q.fmt.chars_m1 || pop_byte == CODE_EOR_STOP) begin
        d.fill_done = 1'b1; // R11
      end
      if (pop_byte == CODE_EOS_STOP) begin
        d.fill_done = 1'b1; // R13
        d.stop_frame = 1'b1; // R13
      end
    end
    d.fifo_cnt = q.fifo_cnt + {1'b0, push} - {1'b0, pop};

    // Character clock and raster counters
    ce = q.div_cnt == DIV_LAST;
    d.div_cnt = ce ? 8'h00 : q.div_cnt + 8'h01;
    line_end = ce & (q.char_cnt == htotal_m1);
    row_end = line_end & (q.line_cnt == q.fmt.lines_m1);
    frame_end = row_end & (q.row_cnt == vtotal_m1);
    at_cursor = (q.char_cnt[6:0] == q.cur_col) & (q.row_cnt[5:0] == q.cur_row) & in_hdisp & in_vdisp;
    ch = (in_hdisp && q.char_cnt[6:0] <= ROW_LAST) ? q.rowbuf[q.disp][q.char_cnt[6:0]] : 8'h00;
    if (ce && q.burst_left == 4'h0) begin
      if (q.space_cnt == 6'h00) begin
        d.burst_left = burst_len; // R14
      end else begin
        d.space_cnt = q.space_cnt - 6'h01;
      end
    end
    if (ce) begin
      d.char_cnt = line_end ? 8'h00 : q.char_cnt + 8'h01;
      d.char_code = 7'h00;
      if (in_hdisp && in_vdisp && q.display_en) begin
        if (ch == CODE_EOR || ch == CODE_EOR_STOP) begin
          d.blank_row = 1'b1; // R9 R10 R11
        end else if (ch == CODE_EOS || ch == CODE_EOS_STOP) begin
          d.blank_frame = 1'b1; // R9 R12 R13
        end else if (ch[7:6] == ATTR_TAG) begin
          d.attr_rev = ch[ATTR_REV_BIT];
          d.attr_hi = ch[ATTR_HI_BIT];
        end else if (!(q.blank_row || q.blank_frame || q.underrun)) begin
          // Stale bytes behind a stop code must not reach the character generator
          d.char_code = ch[6:0];
        end
      end
      d.line_out = q.line_cnt;
      d.video.horiz_retrace_out = ~in_hdisp; // R1
      d.video.vert_retrace_out = ~in_vdisp; // R1
      // Special codes and attribute bytes occupy a blank cell
      d.video.video_blank_out = ~in_hdisp | ~in_vdisp | ~q.display_en | q.blank_row | q.blank_frame | q.underrun
        | (ch[7:6] == ATTR_TAG) | (ch >= CODE_EOR && ch <= CODE_EOS_STOP) | d.blank_row | d.blank_frame; // R2 R10 R12 R15
      d.video.force_video_on = at_cursor & ~q.fmt.cursor_rev & (q.line_cnt == q.fmt.lines_m1) & q.display_en; // R3
      d.video.invert_video_out = q.fmt.rev_en & in_hdisp & in_vdisp & (d.attr_rev ^ (at_cursor & q.fmt.cursor_rev)); // R4
      d.video.intensity_boost_out = in_hdisp & in_vdisp & d.attr_hi; // R4
    end
    if (line_end) begin
      d.blank_row = 1'b0; // R10
      d.line_cnt = (q.line_cnt == q.fmt.lines_m1) ? 4'h0 : q.line_cnt + 4'h1;
    end
    if (row_end) begin
      d.row_cnt = frame_end ? 7'h00 : q.row_cnt + 7'h01;
      d.attr_rev = 1'b0;
      d.attr_hi = 1'b0;
      if (q.row_cnt == {1'b0, q.fmt.rows_m1}) begin
        d.underrun = 1'b0; // R15
        d.stop_frame = 1'b0; // R13
        // Otherwise a stop code would keep the first row of the next frame from loading
        d.fill_done = 1'b0; // R13
      end
      if (load_win) begin
        // A row not complete by its row boundary cannot be shown safely
        if (!d.fill_done) begin
          d.underrun = 1'b1; // R15
        end
        d.disp = ~q.disp;
        d.fill_cnt = 7'h00;
        d.fill_done = d.stop_frame & ~(q.row_cnt == {1'b0, q.fmt.rows_m1});
      end
      if ((q.fmt.rows_m1 == 6'h00) ? frame_end : (q.row_cnt == {1'b0, q.fmt.rows_m1} - 7'h01)) begin
        d.irq = q.int_en; // R19
      end else if (frame_end) begin
        d.irq = 1'b0;
      end
    end
    if (frame_end) begin
      d.blank_frame = 1'b0; // R12
    end
    if (reg_wr && ctl_f.cmd_sel && bus_f[7:5] == CMD_PRESET) begin
      d.div_cnt = 8'h00; // R8
      d.char_cnt = 8'h00; // R8
      d.line_cnt = 4'h0; // R8
      d.row_cnt = 7'h00; // R8
      d.fill_cnt = 7'h00; // R8
      d.space_cnt = 6'h00; // R8
      d.burst_left = burst_len; // R8
      d.fill_done = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.fmt <= '{FMT_CHARS_M1_DEF, FMT_ROWS_M1_DEF, FMT_LINES_M1_DEF, 1'b0, 1'b0, FMT_HRT_M1_DEF, FMT_VRT_M1_DEF}; // R16
    end else begin
      q <= d;
    end
  end

  // Back-pressure: no request while the buffer cannot take a word
  assign wr_ready_o = q.fifo_cnt != 2'h2;
  assign buf_req_o = load_win & ~q.fill_done & ~q.stop_frame & (q.burst_left != 4'h0) & (q.fifo_cnt == 2'h0); // R14 R11 R13
  assign irq_o = q.irq;
  assign underrun_o = q.underrun;
  assign rd_data_o = q.pen_byte ? {1'b0, q.pen_row} : q.pen_col; // R7
  assign char_code_o = q.char_code;
  assign line_count_o = q.line_out;
  assign video_o = q.video;
endmodule : crtrt_top
`default_nettype wire

// ==== crtrt_pkg.sv ====
// Constants, field layouts and carrier types for the CRT row refresh timing block.
// Assumes a 250 MHz system clock and a host that writes through the sampled pin bundle.
// Summary of operation
// [R1] Drive separate horizontal and vertical retrace outputs for the monitor oscillators.
// [R2] Video blank is high throughout every horizontal and vertical retrace.
// [R3] Force video on drives video high at the cursor, regardless of blanking.
// [R4] Invert video when reverse is enabled; intensity boost asks for a brighter beam.
// [R5] Reset command takes four parameter bytes that set the display format.
// [R6] Start display carries burst settings in its byte; four commands take no parameters.
// [R7] Load cursor takes column and row bytes; light pen read gives two bytes.
// [R8] Preset counters clears every internal counter; the code reloads the burst count instead and keeps the two-entry buffer count.
// [R9] Four special codes in the row buffer act instead of displaying.
// [R10] End of row blanks the remaining positions until the line ends.
// [R11] End of row stop loading blanks likewise and stops requests for that row.
// [R12] End of screen blanks until the frame ends.
// [R13] End of screen stop loading blanks likewise and stops requests until frame end.
// [R14] Burst of 1, 2, 4 or 8 characters per request, with programmable spacing.
// [R15] Row not filled within one row time flags underrun and blanks to vertical retrace.
// [R16] Default format: ten scan lines per row, 63.5 us per scan line; the code gives 63.2 us, as CHAR_DIV_DEF truncates to 158.
// [R17] Host sends a command then 0 to 4 parameters, chip select low, select line steering.
// [R18] Host loads row bytes with chip select high, buffer select and write strobes.
// [R19] Interrupt request rises at the start of the last display row of each frame.
package crtrt_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  localparam int SCAN_LINE_PS = 63500000;
  localparam int LINE_TOTAL_CHARS = 100;
  localparam int CHAR_DIV_DEF = SCAN_LINE_PS / (CLK_PERIOD_PS * LINE_TOTAL_CHARS);
  localparam int ROW_CHARS_DEF = 80;
  localparam int SYNC_W = 13;
  localparam int BURST_SPACE_UNIT = 8;

  localparam logic [2:0] CMD_RESET = 3'h0;
  localparam logic [2:0] CMD_START = 3'h1;
  localparam logic [2:0] CMD_STOP = 3'h2;
  localparam logic [2:0] CMD_PEN = 3'h3;
  localparam logic [2:0] CMD_CURSOR = 3'h4;
  localparam logic [2:0] CMD_INT_EN = 3'h5;
  localparam logic [2:0] CMD_INT_DIS = 3'h6;
  localparam logic [2:0] CMD_PRESET = 3'h7;
  localparam logic [2:0] NPAR_RESET = 3'h4;
  localparam logic [2:0] NPAR_TWO = 3'h2;

  localparam logic [7:0] CODE_EOR = 8'hF0;
  localparam logic [7:0] CODE_EOR_STOP = 8'hF1;
  localparam logic [7:0] CODE_EOS = 8'hF2;
  localparam logic [7:0] CODE_EOS_STOP = 8'hF3;
  localparam logic [1:0] ATTR_TAG = 2'h2;
  localparam int ATTR_REV_BIT = 4;
  localparam int ATTR_HI_BIT = 0;

  localparam logic [6:0] FMT_CHARS_M1_DEF = 7'h4F;
  localparam logic [5:0] FMT_ROWS_M1_DEF = 6'h18;
  localparam logic [3:0] FMT_LINES_M1_DEF = 4'h9;
  localparam logic [4:0] FMT_HRT_M1_DEF = 5'h13;
  localparam logic [1:0] FMT_VRT_M1_DEF = 2'h1;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic cmd_sel;
    logic row_buffer_select;
    logic pen;
    logic [6:0] unused_pad;
  } crtrt_ctl_t;

  typedef struct packed {
    logic horiz_retrace_out;
    logic vert_retrace_out;
    logic video_blank_out;
    logic force_video_on;
    logic invert_video_out;
    logic intensity_boost_out;
  } crtrt_video_t;

  typedef struct packed {
    logic [6:0] chars_m1;
    logic [5:0] rows_m1;
    logic [3:0] lines_m1;
    logic cursor_rev;
    logic rev_en;
    logic [4:0] hrt_m1;
    logic [1:0] vrt_m1;
  } crtrt_fmt_t;
endpackage : crtrt_pkg

// ==== crtrt_host_model.sv ====
// Host controller model: command, parameter, row-buffer and pen traffic.
// Assumes the block samples its pins through synchronisers, so each level is held several clocks.
`timescale 1ns/1ps
`default_nettype none
module crtrt_host_model (
  input wire logic sys_clk_i,
  input wire logic [7:0] rd_data_i,
  output var crtrt_pkg::crtrt_ctl_t ctl_o,
  output logic [7:0] data_o
);
  import crtrt_pkg::*;
  initial begin
    ctl_o = 13'h1C00;
    data_o = 8'hA5;
  end
  // Strobe held 5 clocks, data 4 clocks past release, idle high 8 clocks
  task automatic xfer(input logic rd, input logic cs_n, input logic sel, input logic bs, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge sys_clk_i);
    #1;
    ctl_o.cs_n = cs_n;
    ctl_o.cmd_sel = sel;
    ctl_o.row_buffer_select = bs;
    data_o = d;
    @(posedge sys_clk_i);
    #1;
    q = rd_data_i;
    if (rd) begin
      ctl_o.rd_n = 1'b0;
    end else begin
      ctl_o.wr_n = 1'b0;
    end
    repeat (5) @(posedge sys_clk_i);
    #1;
    ctl_o.wr_n = 1'b1;
    ctl_o.rd_n = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    // Released bus must not keep showing the old byte
    data_o = ~d;
    ctl_o.cs_n = 1'b1;
    ctl_o.row_buffer_select = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : xfer
  task automatic wr_reg(input logic sel, input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, 1'b0, sel, 1'b0, d, q);
  endtask : wr_reg
  task automatic wr_buf(input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b0, 1'b1, 1'b0, 1'b1, d, q);
  endtask : wr_buf
  task automatic rd_reg(output logic [7:0] q);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, 8'h5A, q);
  endtask : rd_reg
  task automatic pen_pulse;
    @(posedge sys_clk_i);
    #1;
    ctl_o.pen = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    #1;
    ctl_o.pen = 1'b0;
  endtask : pen_pulse
endmodule : crtrt_host_model
`default_nettype wire

// ==== crtrt_top_properties.sv ====
// Port-level assertions for the CRT row refresh timing top.
// Assumes every programmed format keeps the 20-char horizontal retrace.
`timescale 1ns/1ps
`default_nettype none
module crtrt_props #(
  parameter int CHAR_DIV = crtrt_pkg::CHAR_DIV_DEF,
  parameter int ROW_CHARS = crtrt_pkg::ROW_CHARS_DEF
) (
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire crtrt_pkg::crtrt_ctl_t ctl_i,
  input wire logic [7:0] data_i,
  input wire logic [7:0] rd_data_o,
  input wire logic wr_ready_o,
  input wire logic buf_req_o,
  input wire logic irq_o,
  input wire logic underrun_o,
  input wire logic [6:0] char_code_o,
  input wire logic [3:0] line_count_o,
  input wire crtrt_pkg::crtrt_video_t video_o
);
  import crtrt_pkg::*;
  localparam int HRT_CLKS = (int'(FMT_HRT_M1_DEF) + 1) * CHAR_DIV;
  localparam int BLANK_WIN = 2 * CHAR_DIV + 2;
  typedef struct packed {logic [15:0] hcnt;} crtrt_chk_t;
  crtrt_chk_t st_q, st_d;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  always_comb begin
    st_d = st_q;
    st_d.hcnt = video_o.horiz_retrace_out ? st_q.hcnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  a_hblank_cover: assert property (video_o.horiz_retrace_out |-> video_o.video_blank_out)
    else $error("no blank in hretrace");
  a_vblank_cover: assert property (video_o.vert_retrace_out |-> video_o.video_blank_out)
    else $error("no blank in vretrace");
  a_hrt_width: assert property (video_o.horiz_retrace_out |-> st_q.hcnt < 16'(HRT_CLKS))
    else $error("hretrace too long");
  a_vrt_start: assert property ($rose(video_o.vert_retrace_out) |-> $fell(video_o.horiz_retrace_out))
    else $error("vretrace off line edge");
  a_line_step: assert property (($changed(line_count_o) && line_count_o != 4'h0) |->
    $fell(video_o.horiz_retrace_out)) else $error("line step off line edge");
  a_underrun_blank: assert property ($rose(underrun_o) |-> ##[0:BLANK_WIN] video_o.video_blank_out)
    else $error("underrun not blanked");
  a_irq_row: assert property ($rose(irq_o) |-> ##[0:2] (line_count_o == 4'h0 && !video_o.vert_retrace_out))
    else $error("irq off row start");
  a_irq_clear: assert property ($fell(video_o.vert_retrace_out) |-> ##[0:2] !irq_o)
    else $error("irq kept past frame");
  c_irq: cover property ($rose(irq_o));
  c_underrun: cover property ($rose(underrun_o));
  c_req_taken: cover property ($fell(buf_req_o));
endmodule : crtrt_props
bind crtrt_top crtrt_props #(.CHAR_DIV(CHAR_DIV), .ROW_CHARS(ROW_CHARS)) i_crtrt_props (
  .sys_clk_i(sys_clk_i), .srst_i(srst_i), .ctl_i(ctl_i), .data_i(data_i), .rd_data_o(rd_data_o),
  .wr_ready_o(wr_ready_o), .buf_req_o(buf_req_o), .irq_o(irq_o), .underrun_o(underrun_o),
  .char_code_o(char_code_o), .line_count_o(line_count_o), .video_o(video_o));
`default_nettype wire

// ==== tb.sv ====
// Self-checking bench for the CRT row refresh timing top.
// Assumes a 4-row, 2-line, 80+20-char format programmed through the reset command.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import crtrt_pkg::*;
  localparam int LINE_CLK = 200;
  localparam int ROW_CLK = 2 * LINE_CLK;
  localparam int FRAME = 6 * ROW_CLK;
  typedef struct packed {logic [1:0] code; logic [4:0] cnt;} crtrt_burst_t;
  crtrt_burst_t rows_a [4];
  logic sys_clk_i, srst_i, wr_ready_o, buf_req_o, irq_o, underrun_o, flag;
  crtrt_ctl_t ctl_i;
  logic [7:0] data_i, rd_data_o, q;
  logic [6:0] char_code_o;
  logic [3:0] line_count_o;
  crtrt_video_t video_o;
  int err_total, check_count, n, m, cnt;
  crtrt_top #(.CHAR_DIV(2), .ROW_CHARS(80)) i_crtrt_top (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ctl_i(ctl_i), .data_i(data_i), .rd_data_o(rd_data_o), .wr_ready_o(wr_ready_o), .buf_req_o(buf_req_o),
    .irq_o(irq_o), .underrun_o(underrun_o), .char_code_o(char_code_o), .line_count_o(line_count_o),
    .video_o(video_o));
  crtrt_host_model i_crtrt_host_model (.sys_clk_i(sys_clk_i), .rd_data_i(rd_data_o), .ctl_o(ctl_i),
    .data_o(data_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  function automatic logic sig(input int s);
    case (s)
      0: return buf_req_o;
      1: return video_o.vert_retrace_out;
      2: return irq_o;
      3: return video_o.horiz_retrace_out;
      4: return char_code_o == 7'h41;
      5: return video_o.force_video_on;
      default: return underrun_o;
    endcase
  endfunction : sig
  // Bounded wait; a miss counts as a mismatch
  task automatic wait_sig(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (sig(s) !== v && k < lim) begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end
    if (k >= lim) begin
      check(16'h0000, 16'h0001);
    end
  endtask : wait_sig
  task automatic rise(input int s);
    wait_sig(s, 1'b0, FRAME, n);
    wait_sig(s, 1'b1, FRAME, n);
  endtask : rise
  // Lands just inside the last vertical retrace row, which loads row 0
  task automatic load_window;
    rise(1);
    repeat (ROW_CLK + 4) @(posedge sys_clk_i);
    #1;
    wait_sig(0, 1'b1, 100, n);
  endtask : load_window
  task automatic stop_test;
    if (err_total == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (80000) @(posedge sys_clk_i);
    err_total++;
    stop_test();
  end
  initial begin
    rows_a = '{'{2'h0, 5'h01}, '{2'h1, 5'h02}, '{2'h2, 5'h04}, '{2'h3, 5'h08}};
    srst_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    #1;
    check(video_o, 16'h0000);
    check(wr_ready_o, 16'h0001);
    srst_i = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    i_crtrt_host_model.wr_reg(1'b1, {CMD_RESET, 5'h00});
    foreach (rows_a[i]) begin
      i_crtrt_host_model.wr_reg(1'b0, (i == 0) ? 8'h4F : (i == 1) ? 8'h03 : (i == 2) ? 8'h01 : 8'hB3);
    end
    i_crtrt_host_model.wr_reg(1'b1, {CMD_START, 3'h2, 2'h0});
    rise(1);
    wait_sig(1, 1'b0, FRAME, n);
    wait_sig(1, 1'b1, FRAME, m);
    check(16'(n), 16'(2 * ROW_CLK));
    check(16'(n + m), 16'(FRAME));
    rise(3);
    wait_sig(3, 1'b0, LINE_CLK, n);
    wait_sig(3, 1'b1, LINE_CLK, m);
    check(16'(n), 16'h0028);
    check(16'(n + m), 16'(LINE_CLK));
    foreach (rows_a[i]) begin
      i_crtrt_host_model.wr_reg(1'b1, {CMD_START, 3'h2, rows_a[i].code});
      load_window();
      cnt = 0;
      do begin
        i_crtrt_host_model.wr_buf(8'h41);
        cnt++;
      end while (buf_req_o === 1'b1 && cnt < 16);
      check(16'(cnt), 16'(rows_a[i].cnt));
    end
    i_crtrt_host_model.wr_reg(1'b1, {CMD_CURSOR, 5'h00});
    i_crtrt_host_model.wr_reg(1'b0, 8'h01);
    i_crtrt_host_model.wr_reg(1'b0, 8'h00);
    load_window();
    i_crtrt_host_model.wr_buf(8'h91);
    i_crtrt_host_model.wr_buf(8'h41);
    i_crtrt_host_model.wr_buf(CODE_EOR_STOP);
    flag = 1'b0;
    repeat (150) begin
      @(posedge sys_clk_i);
      #1;
      flag = flag | buf_req_o;
    end
    check(flag, 16'h0000);
    wait_sig(1, 1'b0, 2 * ROW_CLK, n);
    wait_sig(4, 1'b1, 20, n);
    check({video_o.invert_video_out, video_o.intensity_boost_out}, 16'h0003);
    repeat (40) @(posedge sys_clk_i);
    check({video_o.video_blank_out, char_code_o}, 16'h0080);
    rise(3);
    wait_sig(3, 1'b0, LINE_CLK, n);
    wait_sig(5, 1'b1, 20, n);
    load_window();
    i_crtrt_host_model.wr_buf(CODE_EOS_STOP);
    wait_sig(1, 1'b0, 2 * ROW_CLK, n);
    flag = 1'b0;
    n = 0;
    while (video_o.vert_retrace_out !== 1'b1 && n < FRAME) begin
      @(posedge sys_clk_i);
      #1;
      n++;
      flag = flag | buf_req_o | !video_o.video_blank_out;
    end
    check(flag, 16'h0000);
    wait_sig(6, 1'b1, FRAME, n);
    repeat (ROW_CLK / 2) @(posedge sys_clk_i);
    check(video_o.video_blank_out, 16'h0001);
    i_crtrt_host_model.wr_reg(1'b1, {CMD_INT_EN, 5'h00});
    wait_sig(2, 1'b0, 2 * FRAME, n);
    wait_sig(2, 1'b1, 2 * FRAME, n);
    wait_sig(1, 1'b1, 2 * ROW_CLK, n);
    check(16'(n >= ROW_CLK - 2 && n <= ROW_CLK + 2), 16'h0001);
    i_crtrt_host_model.wr_reg(1'b1, {CMD_INT_DIS, 5'h00});
    check(irq_o, 16'h0000);
    repeat (100) @(posedge sys_clk_i);
    i_crtrt_host_model.wr_reg(1'b1, {CMD_PRESET, 5'h00});
    check({video_o.vert_retrace_out, line_count_o}, 16'h0000);
    rise(1);
    wait_sig(1, 1'b0, FRAME, n);
    repeat (100) @(posedge sys_clk_i);
    i_crtrt_host_model.pen_pulse();
    i_crtrt_host_model.wr_reg(1'b1, {CMD_PEN, 5'h00});
    i_crtrt_host_model.rd_reg(q);
    check(16'(q >= 8'h2D && q <= 8'h3C), 16'h0001);
    i_crtrt_host_model.rd_reg(q);
    check(q, 16'h0000);
    i_crtrt_host_model.wr_reg(1'b1, {CMD_STOP, 5'h00});
    flag = 1'b0;
    repeat (FRAME) begin
      @(posedge sys_clk_i);
      #1;
      flag = flag | buf_req_o;
    end
    check(flag, 16'h0000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
